// ==== sensor_consts.svh ====
/*
 * Register map, field positions and sizing constants of the sensor monitor
 * register file.
 * Assumes it is included by its bare name from design files.
 */
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH

// ----------------------------------------------------------------------
// Port geometry
// ----------------------------------------------------------------------
`define PORT_ADDR_BITS 7
`define PORT_DATA_BITS 16
`define CODE_BITS 10
`define CODE_LSB 6
`define REG_COUNT 128
`define STATUS_SPAN 64

// ----------------------------------------------------------------------
// Status register addresses
// ----------------------------------------------------------------------
`define ADDR_TEMPERATURE_RESULT 7'h00
`define ADDR_CORE_SUPPLY_RESULT 7'h01
`define ADDR_AUX_SUPPLY_RESULT 7'h02
`define ADDR_DEDICATED_INPUT_RESULT 7'h03
`define ADDR_REF_POSITIVE_RESULT 7'h04
`define ADDR_REF_NEGATIVE_RESULT 7'h05
`define ADDR_UNUSED_BLOCK_A 7'h06
`define ADDR_SUPPLY_OFFSET_COEFF 7'h08
`define ADDR_CONVERTER_OFFSET_COEFF 7'h09
`define ADDR_AUX_INPUT_FIRST 7'h10
`define ADDR_AUX_INPUT_LAST 7'h1f
`define ADDR_MAX_TEMPERATURE 7'h20
`define ADDR_MIN_TEMPERATURE 7'h24
`define MINMAX_SENSORS 3
`define ADDR_CONTROL_FIRST 7'h40

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MAX_RESET_CODE 10'h000
`define MIN_RESET_CODE 10'h3ff
`define UNDEFINED_READ 16'h0000
`define CONTROL_RESET 16'h0000

// ----------------------------------------------------------------------
// Averaging select encodings
// ----------------------------------------------------------------------
`define AVG_NONE 2'h0
`define AVG_16 2'h1
`define AVG_64 2'h2
`define AVG_256 2'h3
`define AVG_ACC_BITS 24

`endif

// ==== sensor_pkg.sv ====
/*
 * Types shared by the sensor monitor register file.
 * Assumes sensor_consts.svh is on the include path.
 */
`include "sensor_consts.svh"

package sensor_pkg;

    // Configuration port request as presented by the winning requester.
    typedef struct packed {
        logic enable;
        logic write_enable;
        logic [`PORT_ADDR_BITS-1:0] addr;
        logic [`PORT_DATA_BITS-1:0] wdata;
    } port_req_s;

    // Conversion result handed over by the converter front end.
    typedef struct packed {
        logic valid;
        logic [`PORT_ADDR_BITS-1:0] channel;
        logic [`PORT_DATA_BITS-1:0] data;
    } conv_result_s;

    // Which requester currently owns the configuration port.
    typedef enum logic [1:0] {
        OWNER_IDLE = 2'b00,
        OWNER_FABRIC = 2'b01,
        OWNER_JTAG = 2'b10
    } owner_e;

endpackage

// ==== sensor_averager.sv ====
/*
 * Averages successive 16-bit conversions of one sensor channel over 1, 16,
 * 64 or 256 samples and emits the mean as a one-cycle pulse.
 * Assumes samples arrive as single-cycle strobes in the core_clk domain.
 */
`timescale 1ns/1ps
`include "sensor_consts.svh"

module sensor_averager
    import sensor_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [1:0] avg_select,
    input wire logic sample_valid,
    input wire logic [`PORT_DATA_BITS-1:0] sample_data,
    output logic mean_valid,
    output logic [`PORT_DATA_BITS-1:0] mean_data
);

    logic [`AVG_ACC_BITS-1:0] acc;
    logic [8:0] count;
    logic [8:0] target;
    logic [`AVG_ACC_BITS+7:0] total;
    logic [`AVG_ACC_BITS+7:0] wide;

    always_comb begin
        case (avg_select)
            `AVG_16: target = 9'h010;
            `AVG_64: target = 9'h040;
            `AVG_256: target = 9'h100;
            default: target = 9'h001;
        endcase
    end

    // Accumulator wide enough for 256 full-scale 16-bit samples.
    assign wide = {8'h00, acc} +
        {{(`AVG_ACC_BITS-`PORT_DATA_BITS+8){1'b0}}, sample_data};
    assign total = wide;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            acc <= '0;
            count <= 9'h000;
        end else if (sample_valid) begin
            if (count + 9'h001 >= target) begin
                acc <= '0;
                count <= 9'h000;
            end else begin
                acc <= total[`AVG_ACC_BITS-1:0];
                count <= count + 9'h001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mean_valid <= 1'b0;
            mean_data <= '0;
        end else begin
            mean_valid <= sample_valid && (count + 9'h001 >= target);
            if (sample_valid && (count + 9'h001 >= target)) begin
                case (avg_select)
                    `AVG_16: mean_data <= total[19:4];
                    `AVG_64: mean_data <= total[21:6];
                    `AVG_256: mean_data <= total[23:8];
                    default: mean_data <= sample_data;
                endcase
            end
        end
    end

endmodule

// ==== sensor_status_register_file.sv ====
/*
 * Register file of the sensor monitor: 64 read-only status locations and
 * 64 read/write control locations behind the dynamic configuration port,
 * shared between a fabric requester and a JTAG requester.
 * Assumes conversion results arrive one at a time as strobes tagged with a
 * channel number, and both requesters sit in the core_clk domain.
 */
`timescale 1ns/1ps
`include "sensor_consts.svh"

// Functional notes
// - 128 locations of 16 bits, seven-bit port address 00h to 7Fh.
// - Addresses 00h to 3Fh are read-only status locations.
// - Addresses 40h to 7Fh are readable and writable control registers.
// - Fabric or JTAG requester reaches every register through an arbiter.
// - Only control locations take design-time presets; status never does.
// - Each channel result lands at the address equal to its channel number.
// - Temperature result at 00h, 10-bit code in the upper bits.
// - Core supply at 01h and aux supply at 02h, left-aligned.
// - Dedicated differential input result at 03h, upper ten bits.
// - Reference positive and negative results at 04h and 05h.
// - Addresses 06h and 07h unused; reads return meaningless data.
// - Supply sensor offset coefficient held at 08h.
// - Converter offset coefficient held at 09h.
// - Running max and min per on-chip sensor since reset.
// - Temperature optionally averaged over up to 256 samples.
// - Supply measurements optionally averaged over up to 256 samples.
// - Max at 20h to 22h, min at 24h to 26h, left-aligned codes.
// - Auxiliary input results 0 to 15 at 10h to 1Fh.
module sensor_status_register_file
    import sensor_pkg::*;
#(
    parameter logic [`PORT_DATA_BITS-1:0] CONTROL_INIT [`STATUS_SPAN] =
        '{default: `CONTROL_RESET},
    parameter int AVG_CTRL_INDEX = 10,
    parameter int AVG_TEMP_LSB = 0,
    parameter int AVG_SUPPLY_LSB = 2
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire port_req_s fabric_req,
    output logic fabric_ready,
    output logic [`PORT_DATA_BITS-1:0] fabric_rdata,
    input wire port_req_s jtag_req,
    output logic jtag_ready,
    output logic [`PORT_DATA_BITS-1:0] jtag_rdata,
    output logic jtag_busy,
    input wire conv_result_s conv_result,
    output logic [`PORT_DATA_BITS-1:0] control_word [`STATUS_SPAN]
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [`PORT_DATA_BITS-1:0] status_mem [`STATUS_SPAN];
    logic [`PORT_DATA_BITS-1:0] control_mem [`STATUS_SPAN];
    logic [`CODE_BITS-1:0] max_code [`MINMAX_SENSORS];
    logic [`CODE_BITS-1:0] min_code [`MINMAX_SENSORS];

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------
    owner_e owner;
    owner_e next_owner;
    port_req_s grant_req;
    logic grant_write;
    logic [`PORT_DATA_BITS-1:0] read_word;

    always_comb begin
        if (fabric_req.enable) begin
            next_owner = OWNER_FABRIC;
        end else if (jtag_req.enable) begin
            next_owner = OWNER_JTAG;
        end else begin
            next_owner = OWNER_IDLE;
        end
    end

    always_comb begin
        case (next_owner)
            OWNER_FABRIC: grant_req = fabric_req;
            OWNER_JTAG: grant_req = jtag_req;
            default: grant_req = '0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            owner <= OWNER_IDLE;
        end else begin
            owner <= next_owner;
        end
    end

    // A losing JTAG request is dropped, not held; busy shows in the cycle after it lost.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            jtag_busy <= 1'b0;
        end else begin
            jtag_busy <= jtag_req.enable && (next_owner != OWNER_JTAG);
        end
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    // 7-bit decode
    always_comb begin
        read_word = `UNDEFINED_READ;
        if (grant_req.addr >= `ADDR_CONTROL_FIRST) begin
            read_word = control_mem[grant_req.addr[5:0]];
        end else if (grant_req.addr >= `ADDR_MAX_TEMPERATURE &&
                     grant_req.addr < `ADDR_MAX_TEMPERATURE + 7'h03) begin
            read_word = {max_code[2'(grant_req.addr[1:0])], 6'h00};
        end else if (grant_req.addr >= `ADDR_MIN_TEMPERATURE &&
                     grant_req.addr < `ADDR_MIN_TEMPERATURE + 7'h03) begin
            read_word = {min_code[2'(grant_req.addr[1:0])], 6'h00};
        end else if (grant_req.addr == `ADDR_UNUSED_BLOCK_A ||
                     grant_req.addr == `ADDR_UNUSED_BLOCK_A + 7'h01) begin
            read_word = `UNDEFINED_READ;
        end else begin
            read_word = status_mem[grant_req.addr[5:0]];
        end
    end

    assign grant_write = grant_req.enable && grant_req.write_enable;

    // Ready pulses one cycle after the request was taken.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fabric_ready <= 1'b0;
            jtag_ready <= 1'b0;
            fabric_rdata <= '0;
            jtag_rdata <= '0;
        end else begin
            fabric_ready <= (next_owner == OWNER_FABRIC);
            jtag_ready <= (next_owner == OWNER_JTAG);
            if (next_owner == OWNER_FABRIC && !grant_req.write_enable) begin
                fabric_rdata <= read_word;
            end
            if (next_owner == OWNER_JTAG && !grant_req.write_enable) begin
                jtag_rdata <= read_word;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Presets only here
    always_ff @(posedge core_clk) begin
        if (reset) begin
            control_mem <= CONTROL_INIT;
        end else if (grant_write && grant_req.addr >= `ADDR_CONTROL_FIRST) begin
            control_mem[grant_req.addr[5:0]] <= grant_req.wdata;
        end
    end

    assign control_word = control_mem;

    // ------------------------------------------------------------------
    // Averaging of on-chip sensors
    // ------------------------------------------------------------------
    logic [`PORT_DATA_BITS-1:0] avg_word;
    logic [`MINMAX_SENSORS-1:0] sensor_hit;
    logic [`MINMAX_SENSORS-1:0] mean_valid;
    logic [`PORT_DATA_BITS-1:0] mean_data [`MINMAX_SENSORS];

    assign avg_word = control_mem[AVG_CTRL_INDEX];

    genvar s;
    generate
        for (s = 0; s < `MINMAX_SENSORS; s = s + 1) begin : g_sensor
            logic [1:0] sel;
            assign sel = (s == 0) ? avg_word[AVG_TEMP_LSB +: 2]
                                  : avg_word[AVG_SUPPLY_LSB +: 2];
            assign sensor_hit[s] = conv_result.valid &&
                (conv_result.channel == `ADDR_TEMPERATURE_RESULT + 7'(s));
            sensor_averager u_avg (
                .core_clk(core_clk),
                .reset(reset),
                .avg_select(sel),
                .sample_valid(sensor_hit[s]),
                .sample_data(conv_result.data),
                .mean_valid(mean_valid[s]),
                .mean_data(mean_data[s])
            );

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    max_code[s] <= `MAX_RESET_CODE;
                    min_code[s] <= `MIN_RESET_CODE;
                end else if (mean_valid[s]) begin
                    if (mean_data[s][`CODE_LSB +: `CODE_BITS] > max_code[s]) begin
                        max_code[s] <= mean_data[s][`CODE_LSB +: `CODE_BITS];
                    end
                    if (mean_data[s][`CODE_LSB +: `CODE_BITS] < min_code[s]) begin
                        min_code[s] <= mean_data[s][`CODE_LSB +: `CODE_BITS];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Status result storage
    // ------------------------------------------------------------------
    logic direct_store;

    assign direct_store = conv_result.valid &&
        conv_result.channel < `ADDR_MAX_TEMPERATURE &&
        conv_result.channel > `ADDR_AUX_SUPPLY_RESULT &&
        conv_result.channel != `ADDR_UNUSED_BLOCK_A &&
        conv_result.channel != `ADDR_UNUSED_BLOCK_A + 7'h01;

    // Status locations have no preset; reset only clears them to zero.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_mem <= '{default: `UNDEFINED_READ};
        end else begin
            if (direct_store) begin
                status_mem[conv_result.channel[5:0]] <= conv_result.data;
            end
            for (int k = 0; k < `MINMAX_SENSORS; k = k + 1) begin
                if (mean_valid[k]) begin
                    status_mem[k] <= mean_data[k];
                end
            end
        end
    end

endmodule

// ==== sensor_status_register_file_sva.sv ====
/*
 * Port timing checker for the sensor monitor register file.
 * Assumes it is bound to the design top and sees only its ports.
 */
`timescale 1ns/1ps

module sensor_status_register_file_sva
    import sensor_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire port_req_s fabric_req,
    input wire logic fabric_ready,
    input wire logic [15:0] fabric_rdata,
    input wire port_req_s jtag_req,
    input wire logic jtag_ready,
    input wire logic [15:0] jtag_rdata,
    input wire logic jtag_busy,
    input wire conv_result_s conv_result,
    input wire logic [15:0] control_word [64]
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_fabric_answer_next: assert property (
        fabric_req.enable |=> fabric_ready)
        else $error("fabric request not answered next cycle");
    a_fabric_ready_cause: assert property (
        fabric_ready |-> $past(fabric_req.enable))
        else $error("fabric ready without a request");
    a_jtag_served: assert property (
        jtag_req.enable && !fabric_req.enable |=> jtag_ready && !jtag_busy)
        else $error("lone jtag request not served");
    a_jtag_dropped: assert property (
        jtag_req.enable && fabric_req.enable |=> jtag_busy && !jtag_ready)
        else $error("losing jtag request not refused");
    a_busy_cause: assert property (
        jtag_busy |-> $past(jtag_req.enable && fabric_req.enable))
        else $error("jtag busy without a collision");
    a_control_write: assert property (
        fabric_req.enable && fabric_req.write_enable && fabric_req.addr[6]
        |=> control_word[$past(fabric_req.addr[5:0])] ==
            $past(fabric_req.wdata))
        else $error("control write not stored");
    a_fabric_rdata_hold: assert property (
        !fabric_ready && !$past(reset) |-> $stable(fabric_rdata))
        else $error("fabric read data moved between reads");
    a_jtag_rdata_hold: assert property (
        !jtag_ready && !$past(reset) |-> $stable(jtag_rdata))
        else $error("jtag read data moved between reads");
endmodule

// ==== port_requester.sv ====
/*
 * Requester model for the fabric and JTAG sides of the configuration port.
 * Assumes core_clk is the register file clock.
 */
`timescale 1ns/1ps

module port_requester
    import sensor_pkg::*;
(
    input wire logic core_clk,
    output port_req_s fabric_req,
    output port_req_s jtag_req
);
    initial begin
        fabric_req = '0;
        jtag_req = '0;
    end

    task automatic issue(input logic [1:0] who, input logic we,
        input logic [6:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1;
        fabric_req = '{who[0], we, a, d};
        jtag_req = '{who[1], we, a, d};
    endtask

    // Released fields flip so stale values cannot pass for good ones.
    task automatic idle();
        @(posedge core_clk);
        #1;
        fabric_req = {1'b0, ~fabric_req[23:0]};
        jtag_req = {1'b0, ~jtag_req[23:0]};
    endtask
endmodule

// ==== tb_sensor_status_register_file.sv ====
/*
 * Self-checking bench of the sensor monitor register file.
 * Assumes the package, design, checker and requester model compile first.
 */
`timescale 1ns/1ps

module tb_sensor_status_register_file
    import sensor_pkg::*;
    ;
    logic core_clk = 1'b0;
    logic reset;
    port_req_s fabric_req, jtag_req;
    logic fabric_ready, jtag_ready, jtag_busy;
    logic [15:0] fabric_rdata, jtag_rdata, d, e;
    conv_result_s conv_result;
    logic [15:0] control_word [64];
    logic [16:0] fq[$], jq[$];
    logic [23:0] sum;
    logic [6:0] chs [7] = '{7'h03, 7'h04, 7'h05, 7'h08, 7'h09, 7'h10, 7'h1f};
    int fails = 0, total_checks = 0, cycles = 0;

    always #4 core_clk = ~core_clk;

    sensor_status_register_file #(
        .CONTROL_INIT('{2: 16'h5a3c, default: 16'h0000})
    ) u_dut (
        .core_clk, .reset, .fabric_req, .fabric_ready, .fabric_rdata,
        .jtag_req, .jtag_ready, .jtag_rdata, .jtag_busy, .conv_result,
        .control_word
    );
    port_requester u_req (.core_clk, .fabric_req, .jtag_req);

    task automatic cmp(input string n, input logic [15:0] x, y);
        total_checks++;
        if (y !== x) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, x, y);
        end
    endtask

    task automatic check_pop(ref logic [16:0] q[$], input logic [15:0] v,
        input string n);
        logic [16:0] x;
        x = (q.size() == 0) ? 17'h1ffff : q.pop_front();
        if (x[16]) cmp(n, x[15:0], v);
    endtask

    always @(negedge core_clk) begin
        if (fabric_ready === 1'b1) check_pop(fq, fabric_rdata, "fabric");
        if (jtag_ready === 1'b1) check_pop(jq, jtag_rdata, "jtag");
    end

    task automatic rd(input logic [1:0] w, input logic [6:0] a,
        input logic [15:0] x);
        u_req.issue(w, 1'b0, a, 16'h0000);
        if (w[0]) fq.push_back({1'b1, x});
        else jq.push_back({1'b1, x});
    endtask

    task automatic wr(input logic [1:0] w, input logic [6:0] a,
        input logic [15:0] x);
        u_req.issue(w, 1'b1, a, x);
        if (w[0]) fq.push_back(17'h00000);
        else jq.push_back(17'h00000);
    endtask

    task automatic conv(input logic [6:0] ch, input logic [15:0] x);
        @(posedge core_clk);
        #1;
        conv_result = '{1'b1, ch, x};
        @(posedge core_clk);
        #1;
        conv_result = '{1'b0, ~ch, ~x};
    endtask

    task automatic avg(input logic [6:0] ch, input int n, input int sh);
        sum = '0;
        repeat (n) begin
            d = 16'($urandom);
            sum = sum + 24'(d);
            conv(ch, d);
        end
        rd(1, ch, 16'(sum >> sh));
        u_req.idle();
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        reset = 1'b1;
        conv_result = '0;
        void'($urandom(93394));
        repeat (8) @(posedge core_clk);
        #1 reset = 1'b0;
        rd(1, 7'h00, 16'h0000);
        rd(1, 7'h06, 16'h0000);
        rd(1, 7'h20, 16'h0000);
        rd(2, 7'h24, 16'hffc0);
        rd(1, 7'h42, 16'h5a3c);
        u_req.idle();
        $display("done: reset values");
        d = 16'($urandom);
        wr(1, 7'h41, d);
        rd(1, 7'h41, d);
        wr(2, 7'h7f, ~d);
        rd(2, 7'h7f, ~d);
        u_req.idle();
        cmp("control_word", d, control_word[1]);
        $display("done: control access");
        foreach (chs[i]) begin
            d = 16'($urandom);
            conv(chs[i], d);
            rd(1, chs[i], d);
            u_req.idle();
        end
        wr(1, 7'h1f, ~d);
        rd(1, 7'h1f, d);
        u_req.idle();
        $display("done: direct channels");
        for (int c = 0; c < 3; c++) begin
            d = 16'($urandom);
            e = 16'($urandom);
            conv(7'(c), d);
            conv(7'(c), e);
            rd(1, 7'(c), e);
            rd(1, 7'(c + 'h20), ((d > e) ? d : e) & 16'hffc0);
            rd(2, 7'(c + 'h24), ((d < e) ? d : e) & 16'hffc0);
            u_req.idle();
        end
        $display("done: sensors and extremes");
        wr(1, 7'h4a, 16'h0007);
        u_req.idle();
        avg(7'h00, 256, 8);
        avg(7'h02, 16, 4);
        $display("done: averaging");
        wr(1, 7'h41, 16'hc3a5);
        rd(3, 7'h41, 16'hc3a5);
        u_req.idle();
        cmp("jtag_busy", 16'h0001, {15'h0000, jtag_busy});
        rd(2, 7'h41, 16'hc3a5);
        u_req.idle();
        $display("done: arbitration");
        @(posedge core_clk);
        #1 reset = 1'b1;
        @(posedge core_clk);
        #1 reset = 1'b0;
        rd(1, 7'h24, 16'hffc0);
        rd(1, 7'h41, 16'h0000);
        u_req.idle();
        repeat (3) @(posedge core_clk);
        $display("done: second reset");
        finish_test();
    end
endmodule

bind sensor_status_register_file sensor_status_register_file_sva u_sva (
    .core_clk, .reset, .fabric_req, .fabric_ready, .fabric_rdata,
    .jtag_req, .jtag_ready, .jtag_rdata, .jtag_busy, .conv_result,
    .control_word
);
